// *** shared/sync_rx_params.svh ***
// offsets, field positions, masks, reset values and response codes of the receiver
`ifndef SYNC_RX_PARAMS_SVH
`define SYNC_RX_PARAMS_SVH
`define OFF_IRQ_CONTROL     8'h00
`define OFF_IRQ_FLAGS_ONE   8'h04
`define OFF_IRQ_ENABLES_ONE 8'h08
`define OFF_IRQ_PRIO_ONE    8'h0c
`define OFF_RX_STATUS_CTRL  8'h10
`define OFF_RX_BUFFER       8'h14
`define OFF_TX_STATUS_CTRL  8'h18
`define OFF_BAUD_CONTROL    8'h1c
`define OFF_BAUD_DIV_HIGH   8'h20
`define OFF_BAUD_DIV_LOW    8'h24
`define BIT_GLOBAL_IE       7
`define BIT_PERIPH_IE       6
`define BIT_RX_FLAG         5
`define BIT_SERIAL_EN       7
`define BIT_NINTH_EN        6
`define BIT_SINGLE_EN       5
`define BIT_CONT_EN         4
`define BIT_FRAMING_ERR     2
`define BIT_OVERRUN_ERR     1
`define BIT_NINTH_DATA      0
`define BIT_CLK_MASTER      7
`define BIT_SYNC_MODE       4
`define BIT_RX_IDLE         6
`define BIT_WIDE_DIV        3
`define MASK_RX_STATUS_CTRL 8'hf8
`define MASK_TX_STATUS_CTRL 8'hf5
`define MASK_BAUD_CONTROL   8'h3b
`define MASK_IRQ_FLAGS_ONE  8'hdf
`define RESET_BYTE          8'h00
`define RESET_PRIO_ONE      8'hff
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

// *** shared/sync_rx_pkg.sv ***
// types shared by the synchronous master receiver
package sync_rx_pkg;
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_HIGH = 2'b01,
		SH_LOW  = 2'b10
	} shift_state_e;
	typedef struct packed {
		logic       ninth;
		logic [7:0] data;
	} rx_word_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} axi_wr_s;
endpackage

// *** rtl/sync_master_serial_receive.sv ***
// synchronous master serial receiver with axi4-lite register access
// Function
// - serial enable, sync master mode plus single or continuous enable starts reception
// - data line is sampled at the falling edge of the serial clock
// - single enable alone receives one word, then stops
// - continuous enable keeps receiving words until software clears it
// - with both enables set, continuous reception takes precedence
// - ninth-bit enable gives 9-bit words, ninth bit shown in status
// - word done sets complete flag; interrupt only when enabled
// - lower 8 received bits are readable in the receive buffer
// - clearing continuous enable clears a pending receive error
`timescale 1ns/1ps
`include "sync_rx_params.svh"
`default_nettype none
module sync_master_serial_receive (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             serial_clk_o,
	output logic             serial_clk_oe,
	input  wire logic        serial_data_i,
	output logic             rx_irq
);
	import sync_rx_pkg::*;

	logic [7:0]   irq_control_q;
	logic [7:0]   periph_irq_flags_one_q;
	logic [7:0]   periph_irq_enables_one_q;
	logic [7:0]   periph_irq_priority_one_q;
	logic [7:0]   receive_status_control_q;
	logic [7:0]   transmit_status_control_q;
	logic [7:0]   baud_control_q;
	logic [7:0]   baud_divisor_high_q;
	logic [7:0]   baud_divisor_low_q;
	logic         overrun_error_flag_q;
	logic [2:0]   dt_sync_q;
	logic         dt_level_q;
	logic [15:0]  div_cnt_q;
	shift_state_e state_q;
	logic [3:0]   bit_cnt_q;
	logic [8:0]   shift_q;
	rx_word_s     fifo_mem [2];
	logic         fifo_wptr_q;
	logic         fifo_rptr_q;
	logic [1:0]   fifo_cnt_q;
	logic         bvalid_q;
	logic [1:0]   bresp_q;
	logic         rvalid_q;
	logic [31:0]  rdata_q;
	logic [1:0]   rresp_q;
	logic         ck_q;
	axi_wr_s      wr;
	logic         wr_take;
	logic         rd_take;
	logic         rd_pop;
	logic         tick;
	logic         go;
	logic         last_bit;
	logic         word_done;
	logic         push_valid;
	logic         push_ready;
	logic         pop_valid;
	logic         cont_clear;
	logic [15:0]  divisor;
	rx_word_s     head;
	rx_word_s     new_word;
	// true when an address names one of the ten registers
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == `OFF_IRQ_CONTROL) || (a == `OFF_IRQ_FLAGS_ONE) ||
			(a == `OFF_IRQ_ENABLES_ONE) || (a == `OFF_IRQ_PRIO_ONE) ||
			(a == `OFF_RX_STATUS_CTRL) || (a == `OFF_RX_BUFFER) ||
			(a == `OFF_TX_STATUS_CTRL) || (a == `OFF_BAUD_CONTROL) ||
			(a == `OFF_BAUD_DIV_HIGH) || (a == `OFF_BAUD_DIV_LOW);
	endfunction
	// byte-lane-0 write merge through a writable-bit mask
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
		input logic [7:0] mask);
		merge = (old & ~mask) | (nv & mask);
	endfunction
	// axi handshakes: write taken only with address and data together
	assign wr = '{addr: s_axi_awaddr, data: s_axi_wdata, strb: s_axi_wstrb};
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_arready = !rvalid_q;
	assign rd_take = s_axi_arvalid && !rvalid_q;
	assign rd_pop = rd_take && (s_axi_araddr == `OFF_RX_BUFFER) && pop_valid;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	// software clearing the continuous enable this cycle
	assign cont_clear = wr_take && wr.strb[0] && (wr.addr == `OFF_RX_STATUS_CTRL) &&
		receive_status_control_q[`BIT_CONT_EN] && !wr.data[`BIT_CONT_EN];
	// write response channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wr_take) begin
			bvalid_q <= 1'b1;
			bresp_q  <= addr_mapped(wr.addr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	// configuration registers written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_control_q             <= `RESET_BYTE;
			periph_irq_flags_one_q    <= `RESET_BYTE;
			periph_irq_enables_one_q  <= `RESET_BYTE;
			periph_irq_priority_one_q <= `RESET_PRIO_ONE;
			transmit_status_control_q <= `RESET_BYTE;
			baud_control_q            <= `RESET_BYTE;
			baud_divisor_high_q       <= `RESET_BYTE;
			baud_divisor_low_q        <= `RESET_BYTE;
		end else if (wr_take && wr.strb[0]) begin
			unique case (wr.addr)
				`OFF_IRQ_CONTROL: irq_control_q <= wr.data[7:0];
				`OFF_IRQ_FLAGS_ONE: periph_irq_flags_one_q <=
					merge(periph_irq_flags_one_q, wr.data[7:0], `MASK_IRQ_FLAGS_ONE);
				`OFF_IRQ_ENABLES_ONE: periph_irq_enables_one_q <= wr.data[7:0];
				`OFF_IRQ_PRIO_ONE: periph_irq_priority_one_q <= wr.data[7:0];
				`OFF_TX_STATUS_CTRL: transmit_status_control_q <=
					merge(transmit_status_control_q, wr.data[7:0], `MASK_TX_STATUS_CTRL);
				`OFF_BAUD_CONTROL: baud_control_q <=
					merge(baud_control_q, wr.data[7:0], `MASK_BAUD_CONTROL);
				`OFF_BAUD_DIV_HIGH: baud_divisor_high_q <= wr.data[7:0];
				`OFF_BAUD_DIV_LOW: baud_divisor_low_q <= wr.data[7:0];
				default: ;
			endcase
		end
	end
	// receive status/control: software writes, hardware ends single mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_status_control_q <= `RESET_BYTE;
		end else if (wr_take && wr.strb[0] && (wr.addr == `OFF_RX_STATUS_CTRL)) begin
			receive_status_control_q <= merge(receive_status_control_q, wr.data[7:0],
				`MASK_RX_STATUS_CTRL);
		end else if (word_done && !receive_status_control_q[`BIT_CONT_EN]) begin
			receive_status_control_q[`BIT_SINGLE_EN] <= 1'b0;
		end
	end
	// overrun error: set on a word with no room, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_error_flag_q <= 1'b0;
		end else if (word_done && !push_ready) begin
			overrun_error_flag_q <= 1'b1;
		end else if (cont_clear) begin
			overrun_error_flag_q <= 1'b0;
		end
	end
	// read data path; reading the buffer pops the head word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (s_axi_araddr)
				`OFF_IRQ_CONTROL: rdata_q <= {24'h000000, irq_control_q};
				`OFF_IRQ_FLAGS_ONE: rdata_q <= {24'h000000, periph_irq_flags_one_q[7:6],
					pop_valid, periph_irq_flags_one_q[4:0]};
				`OFF_IRQ_ENABLES_ONE: rdata_q <= {24'h000000, periph_irq_enables_one_q};
				`OFF_IRQ_PRIO_ONE: rdata_q <= {24'h000000, periph_irq_priority_one_q};
				// ninth bit shown with the error flags
				`OFF_RX_STATUS_CTRL: rdata_q <= {24'h000000,
					receive_status_control_q[7:3], 1'b0, overrun_error_flag_q,
					pop_valid & head.ninth};
				// lower eight bits of the head word
				`OFF_RX_BUFFER: rdata_q <= {24'h000000, pop_valid ? head.data : 8'h00};
				`OFF_TX_STATUS_CTRL: rdata_q <= {24'h000000, transmit_status_control_q};
				`OFF_BAUD_CONTROL: rdata_q <= {24'h000000, baud_control_q[7],
					state_q == SH_IDLE, baud_control_q[5:0]};
				`OFF_BAUD_DIV_HIGH: rdata_q <= {24'h000000, baud_divisor_high_q};
				`OFF_BAUD_DIV_LOW: rdata_q <= {24'h000000, baud_divisor_low_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	// complete flag gated by receive, peripheral and global enables
	assign rx_irq = pop_valid && periph_irq_enables_one_q[`BIT_RX_FLAG] &&
		irq_control_q[`BIT_PERIPH_IE] && irq_control_q[`BIT_GLOBAL_IE];
	// data pin: three stages, level accepted when the last two agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dt_sync_q  <= 3'b000;
			dt_level_q <= 1'b0;
		end else begin
			dt_sync_q <= {dt_sync_q[1:0], serial_data_i};
			if (dt_sync_q[1] == dt_sync_q[2]) begin
				dt_level_q <= dt_sync_q[2];
			end
		end
	end

	// reception runs in synchronous master mode with an enable set
	assign go = receive_status_control_q[`BIT_SERIAL_EN] &&
		transmit_status_control_q[`BIT_SYNC_MODE] &&
		transmit_status_control_q[`BIT_CLK_MASTER] && !overrun_error_flag_q &&
		(receive_status_control_q[`BIT_SINGLE_EN] ||
		receive_status_control_q[`BIT_CONT_EN]);
	assign divisor = baud_control_q[`BIT_WIDE_DIV] ?
		{baud_divisor_high_q, baud_divisor_low_q} : {8'h00, baud_divisor_low_q};
	assign tick = (div_cnt_q == divisor);

	// baud divider: one tick every divisor+1 cycles while receiving
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q <= 16'h0000;
		end else if (!go || tick) begin
			div_cnt_q <= 16'h0000;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	assign last_bit = (bit_cnt_q == (receive_status_control_q[`BIT_NINTH_EN] ?
		4'h8 : 4'h7));
	assign word_done = go && tick && (state_q == SH_HIGH) && last_bit;
	assign new_word = receive_status_control_q[`BIT_NINTH_EN] ?
		'{ninth: dt_level_q, data: shift_q[8:1]} :
		'{ninth: 1'b0, data: {dt_level_q, shift_q[8:2]}};

	// shifter: a word starts only while the buffer has room
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= SH_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 9'h000;
			ck_q      <= 1'b0;
		end else if (!go) begin
			state_q   <= SH_IDLE;
			bit_cnt_q <= 4'h0;
			ck_q      <= 1'b0;
		end else if (tick) begin
			unique case (state_q)
				SH_IDLE: begin
					// next word follows while enabled and room remains
					if (push_ready) begin
						state_q <= SH_HIGH;
						ck_q    <= 1'b1;
					end
				end
				SH_HIGH: begin
					// sample on the falling clock edge, lsb first
					ck_q      <= 1'b0;
					shift_q   <= {dt_level_q, shift_q[8:1]};
					bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
					state_q   <= last_bit ? SH_IDLE : SH_LOW;
				end
				SH_LOW: begin
					state_q <= SH_HIGH;
					ck_q    <= 1'b1;
				end
				default: state_q <= SH_IDLE;
			endcase
		end
	end

	// master drives the clock pin, toggling only while enabled
	assign serial_clk_o = ck_q;
	assign serial_clk_oe = receive_status_control_q[`BIT_SERIAL_EN] &&
		transmit_status_control_q[`BIT_CLK_MASTER];

	// two-entry receive buffer between shifter and software
	assign push_valid = word_done;
	assign push_ready = (fifo_cnt_q != 2'd2);
	assign pop_valid = (fifo_cnt_q != 2'd0);
	assign head = fifo_mem[fifo_rptr_q];

	always_ff @(posedge clk) begin
		if (push_valid && push_ready) begin
			fifo_mem[fifo_wptr_q] <= new_word;
		end
	end

	// count falls to zero when the last waiting word is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_wptr_q <= 1'b0;
			fifo_rptr_q <= 1'b0;
			fifo_cnt_q  <= 2'd0;
		end else begin
			if (push_valid && push_ready) begin
				fifo_wptr_q <= !fifo_wptr_q;
			end
			if (rd_pop) begin
				fifo_rptr_q <= !fifo_rptr_q;
			end
			// a completed word raises the flag; push with pop leaves the count unchanged
			unique case ({push_valid && push_ready, rd_pop})
				2'b10: fifo_cnt_q <= fifo_cnt_q + 2'd1;
				2'b01: fifo_cnt_q <= fifo_cnt_q - 2'd1;
				default: fifo_cnt_q <= fifo_cnt_q;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/sync_rx_assertions.sv ***
// concurrent checks on the receiver's bus handshakes and serial clock
`timescale 1ns/1ps
`include "sync_rx_params.svh"
`default_nettype none
module sync_rx_assertions (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        serial_clk_o,
	input wire logic        serial_clk_oe,
	input wire logic        serial_data_i,
	input wire logic        rx_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// one half period of the serial clock at the bench divisor of 3
	sequence half_high_s;
		serial_clk_o [*4];
	endsequence
	sequence half_low_s;
		!serial_clk_o [*4];
	endsequence
	// bus handshakes and responses
	write_ready_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
		else $error("write ready does not follow both valids");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response missing");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& s_axi_rresp == (($past(s_axi_araddr) > `OFF_BAUD_DIV_LOW) ? `RESP_SLVERR : `RESP_OKAY))
		else $error("read response wrong");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("unused read bits not zero");
	// serial clock driven only when enabled, high for exactly four cycles and low for at least four
	clock_drive_a: assert property (serial_clk_o |-> serial_clk_oe)
		else $error("serial clock high while not driven");
	high_phase_a: assert property ($rose(serial_clk_o) |-> half_high_s ##1 !serial_clk_o)
		else $error("serial clock high phase wrong length");
	low_phase_a: assert property ($fell(serial_clk_o) |-> half_low_s)
		else $error("serial clock low phase too short");
endmodule
`default_nettype wire

// *** tb/sync_slave_model.sv ***
// behavioural synchronous slave that shifts queued bits onto the data line
`timescale 1ns/1ps
`default_nettype none
module sync_slave_model (
	input  wire logic clk,
	input  wire logic serial_clk,
	input  wire logic serial_clk_oe,
	output logic      data_o
);
	logic bits_q[$];
	logic line_q = 1'b0;
	logic data_q = 1'b0;
	int   falls = 0;
	assign data_o = data_q;
	// queue a word, lsb first
	task automatic push(input logic [8:0] w, input int n);
		for (int i = 0; i < n; i++) bits_q.push_back(w[i]);
	endtask
	// bit held until the sampling fall, then the next one
	always @(posedge clk) begin
		if (line_q && !(serial_clk && serial_clk_oe)) begin
			falls <= falls + 1;
			if (bits_q.size() > 0) void'(bits_q.pop_front());
		end
		line_q <= serial_clk && serial_clk_oe; // undriven clock reads low
		data_q <= (bits_q.size() > 0) ? bits_q[0] : ~data_q; // no word: line keeps moving
	end
endmodule
`default_nettype wire

// *** tb/sync_master_serial_receive_bench.sv ***
// self-checking bench for the synchronous master receiver
`timescale 1ns/1ps
`include "sync_rx_params.svh"
`default_nettype none
module sync_master_serial_receive_bench;
	import sync_rx_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	axi_wr_s     wr_q = '0;
	logic [7:0]  araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, sck, sck_oe, sdata, rx_irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          fails = 0, cmp_count = 0, seed = 99055, bits = 0;
	rx_word_s    exp_q[$];
	sync_master_serial_receive dut_u (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(wr_q.addr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wr_q.data), .s_axi_wstrb(wr_q.strb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_clk_o(sck), .serial_clk_oe(sck_oe),
		.serial_data_i(sdata), .rx_irq(rx_irq));
	sync_slave_model slave_u (.clk(clk), .serial_clk(sck), .serial_clk_oe(sck_oe), .data_o(sdata));
	// clock of 100 ns
	initial forever #50 clk = ~clk;
	task automatic final_report();
		if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one write: address and data together, response accepted after a random pause
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_q <= '{addr: a, data: {24'h0, d}, strb: 4'hf};
		{awvalid, wvalid} <= 2'b11;
		do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
		@(posedge clk);
		{awvalid, wvalid} <= 2'b00;
		repeat ($random(seed) & 3) @(posedge clk);
		bready <= 1'b1;
		do @(negedge clk); while (bvalid !== 1'b1);
		chk("bresp", (a > `OFF_BAUD_DIV_LOW) ? `RESP_SLVERR : `RESP_OKAY, bresp);
		@(posedge clk);
		bready <= 1'b0;
	endtask
	// one read, response code checked against the map, data accepted after a random pause
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		repeat ($random(seed) & 3) @(posedge clk);
		rready <= 1'b1;
		do @(negedge clk); while (rvalid !== 1'b1);
		d = rdata;
		chk("rresp", (a > `OFF_BAUD_DIV_LOW) ? `RESP_SLVERR : `RESP_OKAY, rresp);
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic wait_flag();
		logic [31:0] v;
		v = 32'h0;
		while (v[`BIT_RX_FLAG] !== 1'b1) rd(`OFF_IRQ_FLAGS_ONE, v);
	endtask
	// queue words at the slave, enable, then read them back
	task automatic rx_case(input logic [7:0] ctrl, input int nw, input logic ie);
		logic [31:0] v;
		rx_word_s    w;
		for (int i = 0; i < nw; i++) begin
			w = 9'($random(seed));
			if (!ctrl[`BIT_NINTH_EN]) w.ninth = 1'b0;
			slave_u.push(w, ctrl[`BIT_NINTH_EN] ? 9 : 8);
			exp_q.push_back(w);
			bits += ctrl[`BIT_NINTH_EN] ? 9 : 8;
		end
		wr(`OFF_RX_STATUS_CTRL, ctrl);
		if (nw > 1) begin
			while (slave_u.falls < bits) @(posedge clk);
			repeat (40) @(posedge clk);
			chk("falls while full", bits, slave_u.falls);
			// clearing the continuous and single enables stops reception
			wr(`OFF_RX_STATUS_CTRL, 8'h80);
		end
		for (int i = 0; i < nw; i++) begin
			wait_flag();
			chk("rx_irq", {31'h0, ie}, {31'h0, rx_irq});
			w = exp_q.pop_front();
			// status read first, then the data word
			rd(`OFF_RX_STATUS_CTRL, v);
			chk("status", ((nw > 1) ? 8'h80 : (ctrl & 8'hdf)) | w.ninth, v);
			rd(`OFF_RX_BUFFER, v);
			chk("buffer", w.data, v);
		end
		rd(`OFF_IRQ_FLAGS_ONE, v);
		chk("flag after read", 32'h0, v & 32'h20);
		chk("irq after read", 32'h0, {31'h0, rx_irq});
		repeat (80) @(posedge clk);
		chk("total falls", bits, slave_u.falls);
	endtask
	initial begin
		logic [31:0] v;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a <= 8'h28; a += 4) begin
			rd(8'(a), v);
			chk("reset value", (a == `OFF_IRQ_PRIO_ONE) ? `RESET_PRIO_ONE : `RESET_BYTE,
				v & ((a == `OFF_BAUD_CONTROL) ? 32'hbf : 32'hffffffff));
		end
		wr(8'h28, 8'h55);
		wr(`OFF_RX_STATUS_CTRL, 8'h00);
		// narrow divisor: low byte 3 alone gives an 800 ns serial clock
		wr(`OFF_BAUD_DIV_LOW, 8'h03);
		wr(`OFF_BAUD_DIV_HIGH, 8'h01);
		wr(`OFF_BAUD_CONTROL, 8'h04);
		rd(`OFF_BAUD_CONTROL, v);
		chk("baud control", 32'h00, v & 32'hbf);
		wr(`OFF_TX_STATUS_CTRL, 8'h90);
		wr(`OFF_RX_STATUS_CTRL, 8'h80);
		wr(`OFF_IRQ_PRIO_ONE, 8'h7f);
		wr(`OFF_IRQ_ENABLES_ONE, 8'h20);
		rx_case(8'ha0, 1, 1'b0);
		wr(`OFF_IRQ_CONTROL, 8'hc0);
		// wide divisor of 3 keeps the same rate
		wr(`OFF_BAUD_DIV_HIGH, 8'h00);
		wr(`OFF_BAUD_CONTROL, 8'h08);
		rx_case(8'he0, 1, 1'b1);
		rx_case(8'hb0, 2, 1'b1);
		final_report();
	end
	// cut a hang short
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule
bind sync_master_serial_receive sync_rx_assertions chk_u (
	.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.serial_clk_o(serial_clk_o), .serial_clk_oe(serial_clk_oe),
	.serial_data_i(serial_data_i), .rx_irq(rx_irq));
`default_nettype wire
